// [logic/pwk_cfg.svh]
// Offsets, field positions, reset values of the port wake / pull-down bank
`ifndef PWK_CFG_SVH
`define PWK_CFG_SVH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define PWK_IDX_WAKE_EN 6'h09
`define PWK_IDX_PCH_BUF 6'h0a
`define PWK_IDX_PULL_DN 6'h0b
`define PWK_IDX_IRQ_STS 6'h10
`define PWK_IDX_IRQ_MSK 6'h11

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PWK_PCH_MSB 1
`define PWK_PDA_MSB 3
`define PWK_PDB_LSB 4
`define PWK_PDB_MSB 7
`define PWK_STS_CHG 0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PWK_RST_WAKE_EN 8'h00
`define PWK_RST_PCH_BUF 2'h0
`define PWK_RST_PULL_DN 8'hff
`define PWK_RST_BYTE 8'h00
`define PWK_RST_RDATA 32'h0000_0000

`endif

// [logic/pwk_pkg.sv]
// Types shared by the port wake / pull-down register bank
package pwk_pkg;
  typedef logic [7:0] pwk_byte_t;
  typedef logic [5:0] pwk_idx_t;
  typedef logic [1:0] pwk_pch_t;
endpackage

// [logic/pwk_regs.sv]
// Port B wake control, program-counter high buffer and pull-down control
`timescale 1ns/10ps
`default_nettype none
`include "pwk_cfg.svh"

module pwk_regs (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Port B pins and core strobe
  input wire logic [7:0] portb_pin,
  input wire logic pcl_write,
  // Core-facing results
  output logic [1:0] program_counter_high_bits,
  output logic wake_req,
  output logic portb_change_flag,
  output logic irq,
  // Pull-down controls, active low
  output logic [3:0] porta_pulldown_off,
  output logic [3:0] portb_pulldown_off
);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  pwk_pkg::pwk_byte_t wake_en_reg;
  pwk_pkg::pwk_pch_t pch_buf_reg;
  pwk_pkg::pwk_byte_t pull_dn_reg;
  pwk_pkg::pwk_pch_t pch_out_reg;
  logic sts_reg;
  logic sts_next;
  logic msk_reg;
  logic wake_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  pwk_pkg::pwk_byte_t sync1_reg;
  pwk_pkg::pwk_byte_t sync2_reg;
  pwk_pkg::pwk_byte_t prev_reg;
  pwk_pkg::pwk_byte_t change_evt;
  pwk_pkg::pwk_idx_t idx;
  logic req;
  logic wr_go;
  logic clr_chg;

  // ----------------------------------------
  // Bus handshake
  // ----------------------------------------
  // One wait cycle per access; read data is latched in it so it stands registered
  assign idx = avs_address[7:2];
  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_reg;
  assign wr_go = avs_write & ack_reg;

  // Acknowledge toggles so back-to-back requests each get a wait cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req & ~ack_reg;
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rdata_next = `PWK_RST_RDATA;
    case (idx)
      `PWK_IDX_WAKE_EN: rdata_next[7:0] = wake_en_reg;
      `PWK_IDX_PCH_BUF: rdata_next[1:0] = pch_buf_reg;
      `PWK_IDX_PULL_DN: rdata_next[7:0] = pull_dn_reg;
      `PWK_IDX_IRQ_STS: rdata_next[`PWK_STS_CHG] = sts_reg;
      `PWK_IDX_IRQ_MSK: rdata_next[`PWK_STS_CHG] = msk_reg;
      default: rdata_next = `PWK_RST_RDATA;
    endcase
  end

  // Read data captured during the wait cycle, held until the next read
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= `PWK_RST_RDATA;
    end else if (avs_read && !ack_reg) begin
      rdata_reg <= rdata_next;
    end
  end
  assign avs_readdata = rdata_reg;

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  // Wake enables
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wake_en_reg <= `PWK_RST_WAKE_EN;
    end else if (wr_go && idx == `PWK_IDX_WAKE_EN) begin
      wake_en_reg <= avs_writedata[7:0];
    end
  end

  // Program-counter high buffer; upper bits are never stored
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pch_buf_reg <= `PWK_RST_PCH_BUF;
    end else if (wr_go && idx == `PWK_IDX_PCH_BUF) begin
      pch_buf_reg <= avs_writedata[`PWK_PCH_MSB:0];
    end
  end

  // Pull-down control; resets to all off so no pin is loaded unasked
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pull_dn_reg <= `PWK_RST_PULL_DN;
    end else if (wr_go && idx == `PWK_IDX_PULL_DN) begin
      pull_dn_reg <= avs_writedata[7:0];
    end
  end
  assign porta_pulldown_off = pull_dn_reg[`PWK_PDA_MSB:0];
  assign portb_pulldown_off = pull_dn_reg[`PWK_PDB_MSB:`PWK_PDB_LSB];

  // Interrupt mask
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      msk_reg <= 1'b0;
    end else if (wr_go && idx == `PWK_IDX_IRQ_MSK) begin
      msk_reg <= avs_writedata[`PWK_STS_CHG];
    end
  end

  // ----------------------------------------
  // Program-counter high load
  // ----------------------------------------
  // Only a low-byte write copies the buffer; jumps never touch it
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pch_out_reg <= `PWK_RST_PCH_BUF;
    end else if (pcl_write) begin
      pch_out_reg <= pch_buf_reg;
    end
  end
  assign program_counter_high_bits = pch_out_reg;

  // ----------------------------------------
  // Port B change detection
  // ----------------------------------------
  // Two-stage synchroniser; first stage feeds nothing but the second
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sync1_reg <= `PWK_RST_BYTE;
      sync2_reg <= `PWK_RST_BYTE;
    end else begin
      sync1_reg <= portb_pin;
      sync2_reg <= sync1_reg;
    end
  end

  // Previous level; reset low, so a pin high at reset shows one change
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prev_reg <= `PWK_RST_BYTE;
    end else begin
      prev_reg <= sync2_reg;
    end
  end

  // Disabled pins are masked before any event forms
  assign change_evt = (sync2_reg ^ prev_reg) & wake_en_reg;

  // Wake request pulse, one cycle per changing cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wake_reg <= 1'b0;
    end else begin
      wake_reg <= |change_evt;
    end
  end
  assign wake_req = wake_reg;

  // Sticky change flag; a new event beats a clear in the same cycle
  assign clr_chg = wr_go && idx == `PWK_IDX_IRQ_STS && avs_writedata[`PWK_STS_CHG];
  assign sts_next = (sts_reg & ~clr_chg) | (|change_evt);
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sts_reg <= 1'b0;
    end else begin
      sts_reg <= sts_next;
    end
  end
  assign portb_change_flag = sts_reg;
  assign irq = sts_reg & msk_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_wake_cause;
    @(posedge ref_clk) disable iff (rst)
    wake_req |-> $past(|((sync2_reg ^ prev_reg) & wake_en_reg));
  endproperty
  a_wake_cause: assert property (p_wake_cause)
    else $error("wake request without an enabled change");

  property p_disabled_quiet;
    @(posedge ref_clk) disable iff (rst)
    (((sync2_reg ^ prev_reg) & wake_en_reg) == 8'h00) |=> !wake_req && ($stable(sts_reg) || !sts_reg);
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet)
    else $error("disabled pin change had an effect");

  property p_pch_write;
    @(posedge ref_clk) disable iff (rst)
    (wr_go && idx == `PWK_IDX_PCH_BUF) |=> pch_buf_reg == $past(avs_writedata[1:0]);
  endproperty
  a_pch_write: assert property (p_pch_write)
    else $error("buffer did not take written bits");

  property p_pch_upper_zero;
    @(posedge ref_clk) disable iff (rst)
    (avs_read && !ack_reg && idx == `PWK_IDX_PCH_BUF) |=> avs_readdata[31:2] == 30'h0000_0000;
  endproperty
  a_pch_upper_zero: assert property (p_pch_upper_zero)
    else $error("buffer upper bits read nonzero");

  property p_pda_write;
    @(posedge ref_clk) disable iff (rst)
    (wr_go && idx == `PWK_IDX_PULL_DN) |=> porta_pulldown_off == $past(avs_writedata[3:0]);
  endproperty
  a_pda_write: assert property (p_pda_write)
    else $error("port A pull-down not updated");

  property p_pdb_write;
    @(posedge ref_clk) disable iff (rst)
    (wr_go && idx == `PWK_IDX_PULL_DN) |=> portb_pulldown_off == $past(avs_writedata[7:4]);
  endproperty
  a_pdb_write: assert property (p_pdb_write)
    else $error("port B pull-down not updated");

  property p_pull_off;
    @(posedge ref_clk) disable iff (rst)
    (wr_go && idx == `PWK_IDX_PULL_DN && avs_writedata[7:0] == 8'hff) |=>
      {portb_pulldown_off, porta_pulldown_off} == 8'hff [*2];
  endproperty
  a_pull_off: assert property (p_pull_off)
    else $error("pull-downs not all off after writing ones");

  property p_pch_load;
    @(posedge ref_clk) disable iff (rst)
    pcl_write |=> program_counter_high_bits == $past(pch_buf_reg);
  endproperty
  a_pch_load: assert property (p_pch_load)
    else $error("high bits not loaded from buffer");

  property p_pch_hold;
    @(posedge ref_clk) disable iff (rst)
    !pcl_write |=> $stable(program_counter_high_bits);
  endproperty
  a_pch_hold: assert property (p_pch_hold)
    else $error("high bits moved without a low-byte write");

  property p_flag_sticky;
    @(posedge ref_clk) disable iff (rst)
    (portb_change_flag && !clr_chg) |=> portb_change_flag;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("change flag dropped without a clear");

  property p_change_sets;
    @(posedge ref_clk) disable iff (rst)
    ($changed(sync2_reg) && ((sync2_reg ^ $past(sync2_reg)) & wake_en_reg) != 8'h00)
      |=> portb_change_flag && wake_req;
  endproperty
  a_change_sets: assert property (p_change_sets)
    else $error("enabled change did not set the flag");

  property p_flag_clear;
    @(posedge ref_clk) disable iff (rst)
    (clr_chg && change_evt == 8'h00) |=> !portb_change_flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("change flag survived a clear with no event");

  property p_flag_no_cause;
    @(posedge ref_clk) disable iff (rst)
    (!portb_change_flag && change_evt == 8'h00) |=> !portb_change_flag;
  endproperty
  a_flag_no_cause: assert property (p_flag_no_cause)
    else $error("change flag rose without an enabled change");

endmodule

`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the port wake / pull-down register bank
`timescale 1ns/10ps
`default_nettype none
`include "pwk_cfg.svh"

module tb;
  // ----------------------------------------
  // Signals and bookkeeping
  // ----------------------------------------
  logic ref_clk, rst, avs_read, avs_write, pcl_write, avs_waitrequest;
  logic wake_req, portb_change_flag, irq;
  logic [7:0] avs_address, portb_pin;
  logic [31:0] avs_writedata, avs_readdata, d;
  logic [1:0] program_counter_high_bits, pc_exp;
  logic [3:0] porta_pulldown_off, portb_pulldown_off;
  int n_mismatch = 0;
  int check_count = 0;
  int n_wake = 0;
  logic [31:0] exp_q[$];
  localparam logic [7:0] A_WAKE = {`PWK_IDX_WAKE_EN, 2'b00};
  localparam logic [7:0] A_PCH = {`PWK_IDX_PCH_BUF, 2'b00};
  localparam logic [7:0] A_PD = {`PWK_IDX_PULL_DN, 2'b00};
  localparam logic [7:0] A_STS = {`PWK_IDX_IRQ_STS, 2'b00};
  localparam logic [7:0] A_MSK = {`PWK_IDX_IRQ_MSK, 2'b00};

  pwk_regs i_pwk_regs (
    .ref_clk(ref_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .portb_pin(portb_pin), .pcl_write(pcl_write),
    .program_counter_high_bits(program_counter_high_bits), .wake_req(wake_req),
    .portb_change_flag(portb_change_flag), .irq(irq),
    .porta_pulldown_off(porta_pulldown_off), .portb_pulldown_off(portb_pulldown_off)
  );

  // ----------------------------------------
  // Clock, watchdog, shared tasks
  // ----------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // Whole run is about four hundred cycles; this leaves ample margin
  initial begin
    #80000;
    n_mismatch++;
    finish_test();
  end

  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Request held until a rising edge samples waitrequest low; released only then
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge ref_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0000_0000);
  endtask

  // Toggle one port B pin and count the wake pulses that follow
  task automatic tog(input int k, input logic [31:0] e);
    int w0;
    w0 = n_wake;
    @(posedge ref_clk);
    portb_pin <= portb_pin ^ (8'h01 << k);
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("wake", e, 32'(n_wake - w0));
  endtask

  // ----------------------------------------
  // Output watchers
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (wake_req === 1'b1) n_wake++;
  end

  // Read data taken at the same rising edge that sees waitrequest low
  always @(posedge ref_clk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      if (exp_q.size() == 0) chk("rd_queue", 32'h0000_0001, 32'h0000_0000);
      else chk("rdata", exp_q.pop_front(), avs_readdata);
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h0000_0000;
    portb_pin = 8'h00;
    pcl_write = 1'b0;
    pc_exp = 2'h0;
    void'($urandom(98));
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    // Reset state: all pull-downs off, nothing pending
    rd(A_WAKE, 32'h0000_0000);
    rd(A_PD, 32'h0000_00ff);
    chk("pd_a", 32'h0000_000f, {28'h0, porta_pulldown_off});
    chk("irq", 32'h0000_0000, {31'h0, irq});
    // Random writes, read-back, pin mapping and buffer loading
    for (int i = 0; i < 6; i++) begin
      d = $urandom;
      bus(1'b1, A_WAKE, d);
      rd(A_WAKE, {24'h0, d[7:0]});
      bus(1'b1, A_PCH, ~d);
      rd(A_PCH, {30'h0, ~d[1:0]});
      chk("pc_hold", {30'h0, pc_exp}, {30'h0, program_counter_high_bits});
      bus(1'b1, A_PD, d);
      rd(A_PD, {24'h0, d[7:0]});
      chk("pd_a", {28'h0, d[3:0]}, {28'h0, porta_pulldown_off});
      chk("pd_b", {28'h0, d[7:4]}, {28'h0, portb_pulldown_off});
      @(posedge ref_clk);
      pcl_write <= 1'b1;
      @(posedge ref_clk);
      pcl_write <= 1'b0;
      pc_exp = ~d[1:0];
      @(negedge ref_clk);
      chk("pc_load", {30'h0, pc_exp}, {30'h0, program_counter_high_bits});
      bus(1'b1, 8'h30, d);
      rd(8'h30, 32'h0000_0000);
    end
    // Per-pin change events: disabled pin silent, enabled pin flags
    bus(1'b1, A_STS, 32'h0000_0001);
    bus(1'b1, A_MSK, 32'h0000_0001);
    for (int n = 0; n < 8; n++) begin
      bus(1'b1, A_WAKE, 32'(8'h01 << n));
      tog((n + 1) % 8, 32'h0000_0000);
      chk("flag0", 32'h0000_0000, {31'h0, portb_change_flag});
      tog(n, 32'h0000_0001);
      chk("flag1", 32'h0000_0001, {31'h0, portb_change_flag});
      chk("irq1", 32'h0000_0001, {31'h0, irq});
      bus(1'b1, A_STS, 32'h0000_0001);
      @(negedge ref_clk);
      chk("flag_clr", 32'h0000_0000, {31'h0, portb_change_flag});
    end
    // Masked flag: sticky, visible in status, no interrupt until unmasked
    bus(1'b1, A_MSK, 32'h0000_0000);
    tog(7, 32'h0000_0001);
    repeat (20) @(posedge ref_clk);
    rd(A_STS, 32'h0000_0001);
    chk("irq_masked", 32'h0000_0000, {31'h0, irq});
    bus(1'b1, A_MSK, 32'h0000_0001);
    @(negedge ref_clk);
    chk("irq_unmask", 32'h0000_0001, {31'h0, irq});
    repeat (4) @(posedge ref_clk);
    finish_test();
  end
endmodule
`default_nettype wire
